// ==== src/fan_smooth_pkg.sv ====
// Constants shared by the fan drive smoothing block
package fan_smooth_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] acou_one_idx   = 8'h62;
    localparam logic [7:0] acou_two_idx   = 8'h63;
    localparam logic [7:0] ramp_cfg_idx   = 8'h70;
    localparam logic [7:0] ramp_stat_idx  = 8'h71;

    // Reset values
    localparam logic [7:0] acou_reset     = 8'h00;
    localparam logic [7:0] cfg_reset      = 8'h00;

    // Field positions, first acoustics register
    localparam int rate_w              = 3;
    localparam int one_rate_pos        = 0;
    localparam int one_en_pos          = 3;
    localparam int tach_two_sync_pos   = 4;
    localparam int floor_one_pos       = 5;
    localparam int floor_two_pos       = 6;
    localparam int floor_three_pos     = 7;

    // Field positions, second acoustics register
    localparam int local_rate_pos      = 0;
    localparam int local_en_pos        = 3;
    localparam int two_rate_pos        = 4;
    localparam int two_en_pos          = 7;

    // Field positions, configuration register
    localparam int timing_pos          = 0;
    localparam int lock_pos            = 1;

    // Full-scale ramp time per unit step, and clock
    localparam longint full_ramp_fast_ms = 37500;
    localparam longint full_ramp_slow_ms = 52200;
    localparam longint duty_full_steps   = 255;
    localparam longint clk_period_ns     = 20;
    localparam longint ns_per_ms         = 1000000;

    // One time slot: full ramp time shared over all duty steps
    localparam longint slot_fast_cyc =
        (full_ramp_fast_ms * ns_per_ms) / (clk_period_ns * duty_full_steps);
    localparam longint slot_slow_cyc =
        (full_ramp_slow_ms * ns_per_ms) / (clk_period_ns * duty_full_steps);

    // Duty increase per time slot for a rate code
    function automatic logic [7:0] step_of(input logic [2:0] code);
        logic [7:0] s;
        unique case (code)
            3'h0:    s = 8'h01;
            3'h1:    s = 8'h02;
            3'h2:    s = 8'h03;
            3'h3:    s = 8'h04;
            3'h4:    s = 8'h08;
            3'h5:    s = 8'h0c;
            3'h6:    s = 8'h18;
            default: s = 8'h30;
        endcase
        return s;
    endfunction : step_of

endpackage : fan_smooth_pkg

// ==== src/ramp_if.sv ====
// Link between the top block and one channel ramp
`timescale 1ns/1ps
interface ramp_if;
    logic [7:0] target;
    logic [7:0] step;
    logic       enable;
    logic       tick;
    logic [7:0] duty;
    logic       busy;

    modport src  (output target, output step, output enable, output tick, input duty, input busy);
    modport ramp (input target, input step, input enable, input tick, output duty, output busy);
endinterface : ramp_if

// ==== src/duty_ramp.sv ====
// Rate-limited duty follower for one temperature channel
`timescale 1ns/1ps
module duty_ramp (
    input wire logic core_clk, // System clock
    input wire logic rst,      // Synchronous reset, high
    input wire logic ce,       // Clock enable
    ramp_if.ramp     ri        // Target, step and result
);
    typedef struct packed {
        logic [7:0] duty;
    } ramp_state_t;

    ramp_state_t st_ff;
    ramp_state_t nxt_st;
    logic [7:0]  gap;

    // Move toward target by one step per slot, never past it
    always_comb
    begin
        nxt_st = st_ff;
        gap    = (st_ff.duty < ri.target) ? (ri.target - st_ff.duty) : (st_ff.duty - ri.target);
        if (!ri.enable)
        begin
            nxt_st.duty = ri.target;
        end
        else if (ri.tick && (gap != 8'h00))
        begin
            if (gap <= ri.step)
                nxt_st.duty = ri.target;
            else if (st_ff.duty < ri.target)
                nxt_st.duty = st_ff.duty + ri.step;
            else
                nxt_st.duty = st_ff.duty - ri.step;
        end
    end

    // State register
    always_ff @(posedge core_clk)
    begin
        if (rst)
            st_ff <= '0;
        else if (ce)
            st_ff <= nxt_st;
    end

    assign ri.duty = st_ff.duty;
    assign ri.busy = (st_ff.duty != ri.target);

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence slot_rise;
        ce && ri.enable && ri.tick && (st_ff.duty < ri.target);
    endsequence

    a_bypass_follow: assert property (ce && !rst && !ri.enable |=> st_ff.duty == $past(ri.target))
        else $error("duty did not follow target with smoothing off");
    a_step_size: assert property (ce && ri.enable && ri.tick |=>
        (st_ff.duty == $past(ri.target)) || (st_ff.duty - $past(st_ff.duty) == $past(ri.step))
        || ($past(st_ff.duty) - st_ff.duty == $past(ri.step)))
        else $error("ramp moved by a wrong amount");
    a_no_overshoot: assert property (slot_rise |=>
        (st_ff.duty <= $past(ri.target)) && (st_ff.duty > $past(st_ff.duty)))
        else $error("ramp overshot or stalled");
    a_hold_between: assert property (ce && ri.enable && !ri.tick |=> $stable(st_ff.duty))
        else $error("duty changed outside a time slot");
endmodule : duty_ramp

// ==== src/fan_smooth_top.sv ====
// Acoustic smoothing and floor control for three fan drive outputs
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
// Behaviour
// - Remote one field limits its duty slew
// - Codes give steps 1,2,3,4,8,12,24,48
// - Fast timing: full ramp 37.5s at code 0
// - Slow timing: full ramp 52.2s at code 0
// - Bit 3 enables remote one smoothing
// - Sync bit set: speed inputs 2-4 synced
// - Sync bit clear: only inputs 3,4 synced
// - Drive one below floor: off or min
// - Drive two below floor: off or min
// - Drive three below floor: off or min
// - Lock bit makes acoustics registers read-only
// - Local field limits local channel slew
// - Both acoustics registers reset to zero
// - Second register bit 3 enables local smoothing
// - Bits 6:4 limit remote two slew
// - Bit 7 enables remote two smoothing
module fan_smooth_top #(
    parameter int ADDR_W        = 9,
    parameter int SLOT_FAST_CYC = int'(fan_smooth_pkg::slot_fast_cyc),
    parameter int SLOT_SLOW_CYC = int'(fan_smooth_pkg::slot_slow_cyc)
) (
    input  wire logic              core_clk,        // System clock, 50 MHz
    input  wire logic              rst,             // Synchronous reset, high
    input  wire logic              ce,              // Clock enable, freezes state when low
    input  wire logic [ADDR_W-1:0] adr_i,           // Wishbone byte address
    input  wire logic [31:0]       dat_i,           // Wishbone write data
    input  wire logic [3:0]        sel_i,           // Wishbone byte selects
    input  wire logic              we_i,            // Wishbone write enable
    input  wire logic              cyc_i,           // Wishbone cycle
    input  wire logic              stb_i,           // Wishbone strobe
    output logic [31:0]            dat_o,           // Wishbone read data
    output logic                   ack_o,           // Wishbone acknowledge
    input  wire logic [2:0][7:0]   chan_target,     // Computed duty: 0 remote one, 1 local, 2 remote two
    input  wire logic [2:0]        pwm_auto,        // Output in automatic mode
    input  wire logic [2:0][1:0]   pwm_src_sel,     // Controlling channel per output
    input  wire logic [2:0]        pwm_below_floor, // Temperature below start minus hysteresis
    input  wire logic [2:0][7:0]   pwm_min_duty,    // Minimum duty per output
    output logic [2:0][7:0]        pwm_duty,        // Duty applied to each output
    output logic [2:0]             tach_sync        // Sync to drive three: {four, three, two}
);
    localparam int CNT_W = 24;

    // Refuse address widths outside 9 to 32 and slot counts the counter cannot hold
    if (ADDR_W < 9 || ADDR_W > 32)
    begin : g_bad_addr
        $error("ADDR_W must be 9 to 32");
    end
    if (SLOT_FAST_CYC < 1 || SLOT_SLOW_CYC < 1 || SLOT_FAST_CYC >= (1 << CNT_W) || SLOT_SLOW_CYC >= (1 << CNT_W))
    begin : g_bad_slot
        $error("slot counts must be 1 to 2**24-1");
    end

    typedef struct packed {
        logic             ack;
        logic [31:0]      rdata;
        logic [7:0]       acou_one;
        logic [7:0]       acou_two;
        logic             slow_timing;
        logic             lock;
        logic [CNT_W-1:0] slot_cnt;
        logic             tick;
        logic [2:0][7:0]  duty;
        logic [2:0]       tach;
    } top_state_t;

    top_state_t         st_ff;
    top_state_t         nxt_st;
    logic [2:0][7:0]    chan_duty;
    logic [2:0]         chan_busy;
    logic [2:0][2:0]    chan_rate;
    logic [2:0]         chan_en;
    logic [2:0]         floor_sel;
    logic [ADDR_W-3:0]  word_idx;
    logic               req;
    logic               wr_now;
    logic [CNT_W-1:0]   slot_fast;
    logic [CNT_W-1:0]   slot_slow;

    assign slot_fast = CNT_W'(SLOT_FAST_CYC - 1);
    assign slot_slow = CNT_W'(SLOT_SLOW_CYC - 1);
    assign word_idx  = adr_i[ADDR_W-1:2];
    assign req       = cyc_i && stb_i;
    assign wr_now    = req && we_i && st_ff.ack && sel_i[0];

    // Per-channel rate and enable fields
    assign chan_rate[0] = st_ff.acou_one[fan_smooth_pkg::one_rate_pos +: fan_smooth_pkg::rate_w];
    assign chan_rate[1] = st_ff.acou_two[fan_smooth_pkg::local_rate_pos +: fan_smooth_pkg::rate_w];
    assign chan_rate[2] = st_ff.acou_two[fan_smooth_pkg::two_rate_pos +: fan_smooth_pkg::rate_w];
    assign chan_en[0]   = st_ff.acou_one[fan_smooth_pkg::one_en_pos];
    assign chan_en[1]   = st_ff.acou_two[fan_smooth_pkg::local_en_pos];
    assign chan_en[2]   = st_ff.acou_two[fan_smooth_pkg::two_en_pos];

    // Floor choice per output
    assign floor_sel[0] = st_ff.acou_one[fan_smooth_pkg::floor_one_pos];
    assign floor_sel[1] = st_ff.acou_one[fan_smooth_pkg::floor_two_pos];
    assign floor_sel[2] = st_ff.acou_one[fan_smooth_pkg::floor_three_pos];

    // One ramp per temperature channel
    ramp_if chan_if [3] ();

    for (genvar g = 0; g < 3; g++)
    begin : g_chan
        assign chan_if[g].target = chan_target[g];
        assign chan_if[g].step   = fan_smooth_pkg::step_of(chan_rate[g]);
        assign chan_if[g].enable = chan_en[g];
        assign chan_if[g].tick   = st_ff.tick;
        assign chan_duty[g]      = chan_if[g].duty;
        assign chan_busy[g]      = chan_if[g].busy;

        duty_ramp u_ramp (
            .core_clk (core_clk),
            .rst      (rst),
            .ce       (ce),
            .ri       (chan_if[g])
        );
    end

    // Next state: bus slave, slot timer, output selection
    always_comb
    begin
        nxt_st     = st_ff;
        nxt_st.ack = req && !st_ff.ack;

        // Read data latched as the request is taken
        if (req && !st_ff.ack)
        begin
            unique case (word_idx)
                (ADDR_W-2)'(fan_smooth_pkg::acou_one_idx):  nxt_st.rdata = {24'h000000, st_ff.acou_one};
                (ADDR_W-2)'(fan_smooth_pkg::acou_two_idx):  nxt_st.rdata = {24'h000000, st_ff.acou_two};
                (ADDR_W-2)'(fan_smooth_pkg::ramp_cfg_idx):  nxt_st.rdata = {30'h00000000, st_ff.lock, st_ff.slow_timing};
                (ADDR_W-2)'(fan_smooth_pkg::ramp_stat_idx): nxt_st.rdata = {29'h00000000, chan_busy};
                default:                                    nxt_st.rdata = 32'h00000000;
            endcase
        end

        // Writes land on the acknowledge edge, blocked once locked
        if (wr_now && !st_ff.lock)
        begin
            unique case (word_idx)
                (ADDR_W-2)'(fan_smooth_pkg::acou_one_idx): nxt_st.acou_one = dat_i[7:0];
                (ADDR_W-2)'(fan_smooth_pkg::acou_two_idx): nxt_st.acou_two = dat_i[7:0];
                (ADDR_W-2)'(fan_smooth_pkg::ramp_cfg_idx):
                begin
                    nxt_st.slow_timing = dat_i[fan_smooth_pkg::timing_pos];
                    nxt_st.lock        = dat_i[fan_smooth_pkg::lock_pos];
                end
                default: ;
            endcase
        end

        // Time slot: length set by the timing bit
        nxt_st.tick = 1'b0;
        if (st_ff.slot_cnt == '0)
        begin
            nxt_st.tick     = 1'b1;
            nxt_st.slot_cnt = st_ff.slow_timing ? slot_slow : slot_fast;
        end
        else
        begin
            nxt_st.slot_cnt = st_ff.slot_cnt - 1'b1;
        end

        // Output duty: floor in automatic mode when below floor, else controlling channel
        for (int i = 0; i < 3; i++)
        begin
            if (pwm_auto[i] && pwm_below_floor[i])
                nxt_st.duty[i] = floor_sel[i] ? pwm_min_duty[i] : 8'h00;
            else if (pwm_src_sel[i] == 2'h0)
                nxt_st.duty[i] = chan_duty[0];
            else if (pwm_src_sel[i] == 2'h1)
                nxt_st.duty[i] = chan_duty[1];
            else
                nxt_st.duty[i] = chan_duty[2];
        end

        // Speed inputs three and four always follow drive three
        nxt_st.tach = {2'b11, st_ff.acou_one[fan_smooth_pkg::tach_two_sync_pos]};
    end

    // State register, reset to documented defaults
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            st_ff             <= '0;
            st_ff.acou_one    <= fan_smooth_pkg::acou_reset;
            st_ff.acou_two    <= fan_smooth_pkg::acou_reset;
            st_ff.slow_timing <= fan_smooth_pkg::cfg_reset[fan_smooth_pkg::timing_pos];
            st_ff.lock        <= fan_smooth_pkg::cfg_reset[fan_smooth_pkg::lock_pos];
        end
        else if (ce)
        begin
            st_ff <= nxt_st;
        end
    end

    assign ack_o     = st_ff.ack;
    assign dat_o     = st_ff.rdata;
    assign pwm_duty  = st_ff.duty;
    assign tach_sync = st_ff.tach;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence acou_one_write;
        ce && wr_now && !st_ff.lock && (word_idx == (ADDR_W-2)'(fan_smooth_pkg::acou_one_idx));
    endsequence

    sequence locked_write;
        ce && st_ff.lock && wr_now;
    endsequence

    a_ack_one_cycle: assert property (ce && ack_o |=> !ack_o)
        else $error("acknowledge held longer than one cycle");
    a_write_lands: assert property (acou_one_write |=> st_ff.acou_one == $past(dat_i[7:0]))
        else $error("acoustics write did not land");
    a_lock_blocks: assert property (locked_write |=> $stable(st_ff.acou_one) && $stable(st_ff.acou_two))
        else $error("write changed a locked register");
    a_lock_sticky: assert property (st_ff.lock |=> st_ff.lock)
        else $error("lock bit cleared without reset");
    a_reset_zero: assert property (@(posedge core_clk) disable iff (1'b0)
        rst |=> (st_ff.acou_one == 8'h00) && (st_ff.acou_two == 8'h00))
        else $error("acoustics registers not zero after reset");
    // Sampled reset in antecedents: the release edge itself still resets state
    a_slot_reload: assert property (ce && !rst && st_ff.slot_cnt == '0 |=>
        st_ff.tick && (st_ff.slot_cnt == ($past(st_ff.slow_timing) ? slot_slow : slot_fast)))
        else $error("slot counter reloaded wrong length");
    a_tach_sync: assert property (ce && !rst |=> tach_sync == {2'b11, $past(st_ff.acou_one[4])})
        else $error("speed input sync mask wrong");
    a_floor_one: assert property (ce && !rst && pwm_auto[0] && pwm_below_floor[0] |=>
        pwm_duty[0] == ($past(floor_sel[0]) ? $past(pwm_min_duty[0]) : 8'h00))
        else $error("drive one floor wrong");
    a_floor_two: assert property (ce && !rst && pwm_auto[1] && pwm_below_floor[1] |=>
        pwm_duty[1] == ($past(floor_sel[1]) ? $past(pwm_min_duty[1]) : 8'h00))
        else $error("drive two floor wrong");
    a_floor_three: assert property (ce && !rst && pwm_auto[2] && pwm_below_floor[2] |=>
        pwm_duty[2] == ($past(floor_sel[2]) ? $past(pwm_min_duty[2]) : 8'h00))
        else $error("drive three floor wrong");
endmodule : fan_smooth_top

// ==== verif/testbench.sv ====
// Self-checking bench for the fan drive smoothing block
`timescale 1ns/1ps
module testbench;
    logic             core_clk, rst, ce, we_i, cyc_i, stb_i, ack_o;
    logic [8:0]       adr_i;
    logic [31:0]      dat_i, dat_o, rd;
    logic [3:0]       sel_i;
    logic [2:0][7:0]  tgt, mind, pwm_duty;
    logic [2:0]       pwm_auto, below, tach_sync;
    logic [2:0][1:0]  src;
    int               error_cnt, checks_done, cyc_cnt;
    logic [3:0]       wb_sel;

    fan_smooth_top #(.SLOT_FAST_CYC(4), .SLOT_SLOW_CYC(6)) fan_smooth_top_inst (
        .core_clk(core_clk), .rst(rst), .ce(ce), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
        .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
        .chan_target(tgt), .pwm_auto(pwm_auto), .pwm_src_sel(src), .pwm_below_floor(below),
        .pwm_min_duty(mind), .pwm_duty(pwm_duty), .tach_sync(tach_sync));

    // Clock, 20 ns period
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // Hang guard
    always @(posedge core_clk)
    begin
        cyc_cnt++;
        if (cyc_cnt == 40000)
        begin
            error_cnt++;
            finish_test();
        end
    end

    // Duty steps per rate code
    function automatic logic [7:0] step_tbl(input logic [2:0] c);
        logic [7:0] t [8];
        t = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h0c, 8'h18, 8'h30};
        return t[c];
    endfunction : step_tbl

    // Next duty one slot on, clamped at target
    function automatic logic [7:0] toward(input logic [7:0] p, input logic [7:0] t, input logic [7:0] s);
        if (p < t)
            return (t - p > s) ? p + s : t;
        return (p - t > s) ? p - s : t;
    endfunction : toward

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One classic Wishbone cycle, waits for ack
    task automatic wb(input logic [8:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge core_clk);
        adr_i <= a; we_i <= w; dat_i <= d; sel_i <= wb_sel; cyc_i <= 1'b1; stb_i <= 1'b1;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (ack_o !== 1'b1 && n < 50);
        if (n >= 50)
            chk(ack_o, 1'b1);
        q = dat_o;
        cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
    endtask : wb

    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb(a, 1'b1, {24'h0, d}, q);
    endtask : wr

    // Ramp up to a random target then back to zero on one channel
    task automatic ramp(input int ch, input logic [2:0] code, input logic slow);
        logic [7:0] prev, t, s;
        int gap, nchg, n;
        s = step_tbl(code);
        wr(9'h188, 8'h00);
        wr(9'h18c, 8'h00);
        wr(9'h1c0, {7'h0, slow});
        @(posedge core_clk) tgt[ch] <= 8'h00;
        repeat (3) @(posedge core_clk);
        if (ch == 0) wr(9'h188, {5'h01, code});
        if (ch == 1) wr(9'h18c, {5'h01, code});
        if (ch == 2) wr(9'h18c, {1'b1, code, 4'h0});
        for (int ph = 0; ph < 2; ph++)
        begin
            t = ph ? 8'h00 : 8'h40 + 8'($urandom % 128);
            @(posedge core_clk) tgt[ch] <= t;
            prev = pwm_duty[ch];
            gap = 0; nchg = 0; n = 0;
            while (pwm_duty[ch] !== t && n < 3000)
            begin
                @(posedge core_clk);
                n++; gap++;
                if (pwm_duty[ch] !== prev)
                begin
                    chk(pwm_duty[ch], toward(prev, t, s));
                    if (nchg > 0) chk(32'(gap), slow ? 32'h6 : 32'h4);
                    nchg++; gap = 0; prev = pwm_duty[ch];
                end
            end
            chk(pwm_duty[ch], t);
        end
        $display("ramp ch=%0d code=%0d slow=%0d done", ch, code, slow);
    endtask : ramp

    task automatic finish_test();
        $display("checks=%0d errors=%0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finish_test

    // Main sequence
    initial
    begin
        error_cnt = 0; checks_done = 0; cyc_cnt = 0;
        wb_sel = 4'hf;
        rst = 1'b1; ce = 1'b1; adr_i = '0; dat_i = '0; sel_i = '0; we_i = 1'b0; cyc_i = 1'b0;
        stb_i = 1'b0; tgt = '0; mind = '0; pwm_auto = '0; below = '0; src = {2'h2, 2'h1, 2'h0};
        void'($urandom(48835));
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        // Reset values and unmapped read
        wb(9'h188, 1'b0, '0, rd); chk(rd, 32'h0);
        wb(9'h18c, 1'b0, '0, rd); chk(rd, 32'h0);
        wb(9'h100, 1'b0, '0, rd); chk(rd, 32'h0);
        chk(pwm_duty, 24'h0);
        $display("reset test done");
        // Sync selection of speed inputs
        wr(9'h188, 8'h10);
        repeat (2) @(posedge core_clk);
        chk(tach_sync, 3'b111);
        wr(9'h188, 8'h00);
        repeat (2) @(posedge core_clk);
        chk(tach_sync, 3'b110);
        $display("sync test done");
        // Smoothing off: random targets and routing pass straight through
        for (int i = 0; i < 12; i++)
        begin
            @(posedge core_clk);
            tgt <= 24'($urandom);
            src <= 6'($urandom);
            repeat (3) @(posedge core_clk);
            for (int o = 0; o < 3; o++)
                chk(pwm_duty[o], tgt[src[o] == 2'h3 ? 2 : src[o]]);
        end
        $display("bypass test done");
        // Clock enable low freezes every output; byte select 0 refuses a write
        rd = 32'(pwm_duty);
        @(posedge core_clk) tgt <= 24'($urandom);
        ce <= 1'b0;
        repeat (4) @(posedge core_clk);
        chk(32'(pwm_duty), rd);
        ce <= 1'b1;
        repeat (3) @(posedge core_clk);
        for (int o = 0; o < 3; o++)
            chk(pwm_duty[o], tgt[src[o] == 2'h3 ? 2 : src[o]]);
        wb_sel = 4'he;
        wr(9'h188, 8'hff);
        wb_sel = 4'hf;
        wb(9'h188, 1'b0, '0, rd); chk(rd, 32'h0);
        $display("enable test done");
        // Below-floor selection per output, off or minimum
        @(posedge core_clk);
        src <= {2'h2, 2'h1, 2'h0}; pwm_auto <= 3'b111; below <= 3'b111;
        for (int o = 0; o < 3; o++)
            for (int b = 0; b < 2; b++)
            begin
                @(posedge core_clk) mind <= 24'($urandom);
                wr(9'h188, 8'(b << (5 + o)));
                repeat (2) @(posedge core_clk);
                for (int k = 0; k < 3; k++)
                    chk(pwm_duty[k], (k == o && b == 1) ? mind[k] : 8'h00);
            end
        @(posedge core_clk) pwm_auto <= 3'b000;
        below <= 3'b000;
        $display("floor test done");
        // Every rate code on rotating channels, both timings
        for (int c = 0; c < 8; c++)
            ramp(c % 3, 3'(c), 1'(c % 2));
        // Lock freezes the acoustics registers
        wr(9'h188, 8'h5a);
        wr(9'h18c, 8'ha5);
        wr(9'h1c0, 8'h02);
        wr(9'h188, 8'hff);
        wr(9'h18c, 8'h00);
        wb(9'h188, 1'b0, '0, rd); chk(rd, 32'h5a);
        wb(9'h18c, 1'b0, '0, rd); chk(rd, 32'ha5);
        wb(9'h1c0, 1'b0, '0, rd); chk(rd, 32'h2);
        // Status shows the remote one ramp still under way
        @(posedge core_clk) tgt[0] <= 8'hff;
        wb(9'h1c4, 1'b0, '0, rd); chk(rd, 32'h1);
        $display("lock test done");
        // Mid-run reset clears the lock and both acoustics registers
        @(posedge core_clk) rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        wb(9'h188, 1'b0, '0, rd); chk(rd, 32'h0);
        wb(9'h18c, 1'b0, '0, rd); chk(rd, 32'h0);
        wr(9'h188, 8'h3c);
        wb(9'h188, 1'b0, '0, rd); chk(rd, 32'h3c);
        $display("second reset test done");
        finish_test();
    end
endmodule : testbench
